/* rtl/flash_host_pkg.sv */
package flash_host_pkg;
   // command codes
   localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
   localparam logic [7:0] CODE_RESET = 8'hF0;
   localparam logic [7:0] CODE_AUTO_SELECT = 8'h90;
   localparam logic [7:0] CODE_PROGRAM = 8'hA0;
   localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CODE_ERASE_CONFIRM = 8'h30;
   // unlock addresses, byte-wide and word-wide
   localparam logic [17:0] ADDR_UNLOCK1_BYTE = 18'h0AAAA;
   localparam logic [17:0] ADDR_UNLOCK1_WORD = 18'h05555;
   localparam logic [17:0] ADDR_UNLOCK2_BYTE = 18'h05555;
   localparam logic [17:0] ADDR_UNLOCK2_WORD = 18'h02AAA;
   // auto-select read addresses
   localparam logic [17:0] ADDR_MAKER_CODE = 18'h00000;
   localparam logic [17:0] ADDR_DEVICE_CODE = 18'h00001;
   localparam logic [17:0] ADDR_PROTECT_LOW = 18'h00002;
   localparam int BLOCK_ADDR_LSB = 12;
   // status bit positions
   localparam int POS_DATA_POLLING = 7;
   localparam int POS_TOGGLE_STATUS = 6;
   localparam int POS_ERROR_FLAG = 5;
   localparam int POS_ERASE_TIMER = 3;
   localparam int POS_BLOCK_TOGGLE = 2;
   // host register map
   localparam logic [3:0] REG_CONTROL = 4'h0;
   localparam logic [3:0] REG_ADDRESS = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RDATA = 4'h4;
   localparam logic [15:0] RESET_VALUE_ZERO = 16'h0000;
   // control op codes written to REG_CONTROL
   localparam logic [2:0] OP_RESET = 3'h1;
   localparam logic [2:0] OP_AUTO_SELECT = 3'h2;
   localparam logic [2:0] OP_PROGRAM = 3'h3;
   localparam logic [2:0] OP_ERASE = 3'h4;
   localparam logic [2:0] OP_ERASE_MORE = 3'h5;
   localparam logic [2:0] OP_READ = 3'h6;
   // timing
   localparam int CLOCK_MHZ = 100;
   localparam int BUS_PHASE_NS = 60;
   localparam int BUS_PHASE_CYCLES = (BUS_PHASE_NS * CLOCK_MHZ + 999) / 1000;
   localparam int RESET_WAIT_US = 10;
   localparam int RESET_WAIT_CYCLES = RESET_WAIT_US * CLOCK_MHZ;
   localparam int SEQ_LEN_MAX = 6;

   typedef struct packed {
      logic [17:0] addr;
      logic [15:0] data;
   } bus_cycle_s;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe;
   } strobe_s;
endpackage

/* rtl/flash_seq_rom.sv */
`timescale 1ns/10ps
module flash_seq_rom
   import flash_host_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // lookup
   input wire logic [2:0] op,
   input wire logic [2:0] step,
   input wire logic word_mode,
   input wire logic [17:0] user_addr,
   input wire logic [15:0] user_data,
   // registered answer
   output bus_cycle_s cycle_q
);
   bus_cycle_s cycle_d;
   logic [17:0] a1;
   logic [17:0] a2;

   always_comb begin
      a1 = word_mode ? ADDR_UNLOCK1_WORD : ADDR_UNLOCK1_BYTE;
      a2 = word_mode ? ADDR_UNLOCK2_WORD : ADDR_UNLOCK2_BYTE;
      cycle_d.addr = a1;
      cycle_d.data = {8'h00, CODE_UNLOCK1};
      // unlock pair at steps 0/1 and again at 3/4 for erase
      if (step == 3'd0 || (op == OP_ERASE && step == 3'd3)) begin
         cycle_d.addr = a1;
         cycle_d.data = {8'h00, CODE_UNLOCK1};
      end else if (step == 3'd1 || (op == OP_ERASE && step == 3'd4)) begin
         cycle_d.addr = a2;
         cycle_d.data = {8'h00, CODE_UNLOCK2};
      end else if (step == 3'd2) begin
         if (op == OP_AUTO_SELECT) begin
            cycle_d.data = {8'h00, CODE_AUTO_SELECT};
         end else if (op == OP_PROGRAM) begin
            cycle_d.data = {8'h00, CODE_PROGRAM};
         end else if (op == OP_ERASE) begin
            cycle_d.data = {8'h00, CODE_ERASE_SETUP};
         end else begin
            cycle_d.data = {8'h00, CODE_RESET};
         end
      end else if (step == 3'd3) begin
         cycle_d.addr = user_addr;
         cycle_d.data = user_data;
      end else begin
         cycle_d.addr = user_addr;
         cycle_d.data = {8'h00, CODE_ERASE_CONFIRM};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cycle_q <= '0;
      end else begin
         cycle_q <= cycle_d;
      end
   end
endmodule // flash_seq_rom

/* rtl/flash_host.sv */
`timescale 1ns/10ps
module flash_host
   import flash_host_pkg::*;
#(
   parameter int RESET_WAIT = RESET_WAIT_CYCLES
)(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // flash pins
   output logic [17:0] flash_addr,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_byte_n
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_SETUP = 6'b000010,
      ST_STROBE = 6'b000100,
      ST_HOLD = 6'b001000,
      ST_READ = 6'b010000,
      ST_WAIT = 6'b100000
   } state_e;

   typedef struct packed {
      state_e state;
      logic [2:0] op;
      logic [2:0] step;
      logic [2:0] last_step;
      logic [7:0] phase;
      logic [10:0] wait_cnt;
      logic word_mode;
      logic erase_seen;
      logic [17:0] user_addr;
      logic [15:0] user_data;
      logic [15:0] rdata;
      logic [15:0] prev_read;
      logic toggling;
      logic failed;
      logic [15:0] bus_rdata;
      bus_cycle_s pins;
      strobe_s strb;
   } host_s;

   host_s s_q;
   host_s s_d;
   bus_cycle_s rom_q;
   logic busy;

   flash_seq_rom u_rom (
      .clock(clock),
      .rst_n(rst_n),
      .op(s_q.op),
      .step(s_q.step),
      .word_mode(s_q.word_mode),
      .user_addr(s_q.user_addr),
      .user_data(s_q.user_data),
      .cycle_q(rom_q)
   );

   assign busy = (s_q.state != ST_IDLE);

   always_comb begin
      s_d = s_q;
      s_d.bus_rdata = RESET_VALUE_ZERO;
      // register writes; op start is refused while a sequence runs
      if (reg_write) begin
         if (reg_addr == REG_ADDRESS) begin
            s_d.user_addr = {2'b00, reg_wdata};
         end else if (reg_addr == REG_WDATA) begin
            s_d.user_data = reg_wdata;
         end else if (reg_addr == REG_CONTROL && !busy) begin
            s_d.op = reg_wdata[2:0];
            s_d.word_mode = reg_wdata[4];
            s_d.user_addr[17:16] = reg_wdata[9:8];
            s_d.state = ST_SETUP;
            s_d.phase = 8'h00;
            s_d.step = 3'd0;
            if (reg_wdata[2:0] == OP_READ) begin
               s_d.state = ST_READ;
            end else if (reg_wdata[2:0] == OP_ERASE_MORE) begin
               s_d.step = 3'd5;
            end else if (reg_wdata[2:0] == OP_RESET) begin
               s_d.step = 3'd2;
            end
            if (reg_wdata[2:0] == OP_ERASE) begin
               s_d.last_step = 3'd5;
               s_d.erase_seen = 1'b1;
            end else if (reg_wdata[2:0] == OP_ERASE_MORE) begin
               s_d.last_step = 3'd5;
               s_d.erase_seen = 1'b1;
            end else if (reg_wdata[2:0] == OP_PROGRAM) begin
               s_d.last_step = 3'd3;
            end else begin
               s_d.last_step = 3'd2;
            end
         end
      end
      if (reg_read) begin
         if (reg_addr == REG_STATUS) begin
            s_d.bus_rdata = {11'h000, s_q.word_mode, s_q.failed, s_q.toggling,
               s_q.erase_seen, busy};
         end else if (reg_addr == REG_RDATA) begin
            s_d.bus_rdata = s_q.rdata;
         end else if (reg_addr == REG_ADDRESS) begin
            s_d.bus_rdata = s_q.user_addr[15:0];
         end else if (reg_addr == REG_WDATA) begin
            s_d.bus_rdata = s_q.user_data;
         end else begin
            s_d.bus_rdata = RESET_VALUE_ZERO;
         end
      end
      case (s_q.state)
         ST_IDLE: begin
            s_d.strb = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
         end
         ST_SETUP: begin
            // rom answer for this step is ready one cycle after step changed
            s_d.phase = s_q.phase + 8'h01;
            if (s_q.phase == 8'h01) begin
               s_d.pins = rom_q;
               s_d.strb = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b1};
            end else if (s_q.phase == 8'h02) begin
               s_d.strb.we_n = 1'b0;
               s_d.phase = 8'h00;
               s_d.state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            s_d.phase = s_q.phase + 8'h01;
            if (s_q.phase == 8'(BUS_PHASE_CYCLES - 1)) begin
               s_d.strb.we_n = 1'b1;
               s_d.phase = 8'h00;
               s_d.state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            s_d.phase = s_q.phase + 8'h01;
            if (s_q.phase == 8'(BUS_PHASE_CYCLES - 1)) begin
               s_d.strb = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
               s_d.phase = 8'h00;
               if (s_q.step == s_q.last_step) begin
                  s_d.state = ST_IDLE;
                  if (s_q.op == OP_RESET && s_q.erase_seen) begin
                     s_d.state = ST_WAIT;
                     s_d.wait_cnt = 11'h000;
                  end
                  if (s_q.op == OP_RESET) begin
                     s_d.failed = 1'b0;
                  end
               end else begin
                  s_d.step = s_q.step + 3'd1;
                  s_d.state = ST_SETUP;
               end
            end
         end
         ST_READ: begin
            // array or status read; status bits decoded on every read
            // address settles a cycle before the strobes fall, so the far
            // side never answers a read for a stale address
            s_d.phase = s_q.phase + 8'h01;
            if (s_q.phase == 8'h00) begin
               s_d.pins.addr = s_q.user_addr;
            end else if (s_q.phase == 8'h01) begin
               s_d.strb = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, dq_oe: 1'b0};
            end else if (s_q.phase == 8'(BUS_PHASE_CYCLES + 1)) begin
               s_d.rdata = flash_dq_in;
               s_d.prev_read = flash_dq_in;
               s_d.toggling = (flash_dq_in[POS_TOGGLE_STATUS] !=
                  s_q.prev_read[POS_TOGGLE_STATUS]);
               s_d.failed = s_q.failed | flash_dq_in[POS_ERROR_FLAG];
               s_d.strb = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
               s_d.phase = 8'h00;
               s_d.state = ST_IDLE;
            end
         end
         ST_WAIT: begin
            s_d.wait_cnt = s_q.wait_cnt + 11'h001;
            if (s_q.wait_cnt == 11'(RESET_WAIT - 1)) begin
               s_d.erase_seen = 1'b0;
               s_d.state = ST_IDLE;
            end
         end
         default: begin
            s_d.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.state <= ST_IDLE;
         s_q.strb <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.bus_rdata;
   assign flash_addr = s_q.pins.addr;
   assign flash_dq_out = s_q.pins.data;
   assign flash_dq_oe = s_q.strb.dq_oe;
   assign flash_ce_n = s_q.strb.ce_n;
   assign flash_oe_n = s_q.strb.oe_n;
   assign flash_we_n = s_q.strb.we_n;
   assign flash_byte_n = s_q.word_mode;

   // write strobe low only while chip enabled and driving
   a_we_in_ce: assert property (@(posedge clock) disable iff (!rst_n)
      !flash_we_n |-> (!flash_ce_n && flash_dq_oe)) else $error("we without ce");
   a_we_width: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(flash_we_n) |-> !flash_we_n[*6] ##1 flash_we_n)
      else $error("we pulse width wrong");
   a_no_drive_read: assert property (@(posedge clock) disable iff (!rst_n)
      !flash_oe_n |-> !flash_dq_oe) else $error("drive during read");
   a_unlock_one: assert property (@(posedge clock) disable iff (!rst_n)
      ($fell(flash_we_n) && s_q.step == 3'd0) |->
      flash_dq_out[7:0] == CODE_UNLOCK1) else $error("bad first unlock");
   a_unlock_two: assert property (@(posedge clock) disable iff (!rst_n)
      ($fell(flash_we_n) && s_q.step == 3'd1 && s_q.op != OP_RESET) |->
      flash_dq_out[7:0] == CODE_UNLOCK2) else $error("bad second unlock");
   a_erase_confirm: assert property (@(posedge clock) disable iff (!rst_n)
      ($fell(flash_we_n) && s_q.step == 3'd5) |->
      flash_dq_out[7:0] == CODE_ERASE_CONFIRM) else $error("bad confirm");
   a_reset_wait: assert property (@(posedge clock) disable iff (!rst_n)
      (s_q.state == ST_WAIT && s_q.wait_cnt == 11'h000) |->
      busy[*8]) else $error("reset wait cut short");
   a_unlock_addr: assert property (@(posedge clock) disable iff (!rst_n)
      ($fell(flash_we_n) && s_q.step == 3'd0 && !s_q.word_mode) |->
      flash_addr == ADDR_UNLOCK1_BYTE) else $error("bad unlock address");
endmodule // flash_host

/* tb/flash_dev_model.sv */
`timescale 1ns/10ps
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary
   parameter logic [7:0] PART_ID = 8'hC3, // arbitrary
   parameter time T_PROG = 2us,
   parameter time T_WIN = 100us,
   parameter time T_ERASE = 2us
)(
   // pins
   input wire logic [17:0] addr,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe,
   output logic [15:0] dq_in,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic byte_n
);
   logic [15:0] mem [int];
   logic [5:0] blk [$];
   logic [17:0] la;
   logic [15:0] q = 16'h0000;
   logic [7:0] cmd, pd;
   logic tog = 1'b0;
   int step = 0;
   int mode = 0; // 0 array, 1 ident, 2 program, 3 window, 4 erase
   time due;
   wire wr_n = we_n | ce_n;
   wire rd_n = ce_n | oe_n;
   function automatic bit at(input logic [17:0] b, input logic [17:0] w);
      return byte_n ? la[14:0] == w[14:0] : la[15:0] == b[15:0];
   endfunction
   function automatic bit ok(input int k, input logic [7:0] d);
      if (k == 0) return d == CODE_UNLOCK1 && at(ADDR_UNLOCK1_BYTE, ADDR_UNLOCK1_WORD);
      if (k == 1) return d == CODE_UNLOCK2 && at(ADDR_UNLOCK2_BYTE, ADDR_UNLOCK2_WORD);
      return at(ADDR_UNLOCK1_BYTE, ADDR_UNLOCK1_WORD);
   endfunction
   function automatic logic [15:0] rm(input logic [17:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   // time is settled lazily at each strobe, so no free-running process is needed
   task automatic settle();
      int ks[$];
      if (mode == 3 && $time >= due) begin
         mode = 4;
         due = $time + T_ERASE;
      end
      if (mode == 4 && $time >= due) begin
         foreach (mem[k]) foreach (blk[j]) if (k[17:12] == blk[j]) ks.push_back(k);
         foreach (ks[i]) mem[ks[i]] = 16'h0000;
         foreach (ks[i]) mem.delete(ks[i]);
         mode = 0;
      end
      if (mode == 2 && $time >= due) mode = 0;
   endtask
   task automatic decode(input logic [7:0] d);
      if (step == 3 && cmd == CODE_PROGRAM) begin
         mem[la] = rm(la) & (byte_n ? dq_out : {8'hFF, d});
         pd = d;
         mode = 2;
         due = $time + T_PROG;
         step = 0;
      end else if (mode == 3 && d == CODE_ERASE_CONFIRM) begin
         blk.push_back(la[17:12]);
         due = $time + T_WIN;
      end else if (d == CODE_RESET) begin
         mode = 0;
         step = 0;
      end else if (step == 5 && d == CODE_ERASE_CONFIRM) begin
         blk = {la[17:12]};
         mode = 3;
         due = $time + T_WIN;
         step = 0;
      end else if (step < 5 && ok(step % 3, d)) begin
         if (step == 2) cmd = d;
         step = step + 1;
         if (step == 3 && cmd == CODE_AUTO_SELECT) mode = 1;
         if (step == 3 && !(cmd inside {CODE_PROGRAM, CODE_ERASE_SETUP})) step = 0;
      end else begin
         mode = 0;
         step = 0;
      end
   endtask
   initial dq_in = 16'h0000;
   always @(negedge wr_n) la = addr;
   always @(posedge wr_n) begin
      settle();
      if (dq_oe && mode != 2 && mode != 4) decode(dq_out[7:0]);
   end
   always @(negedge rd_n) begin
      settle();
      if (mode >= 2) begin
         tog = ~tog;
         q = 16'h0000;
         q[POS_DATA_POLLING] = mode == 2 ? ~pd[7] : 1'b0;
         q[POS_TOGGLE_STATUS] = tog;
         q[POS_ERASE_TIMER] = mode == 4;
         q[POS_BLOCK_TOGGLE] = mode == 2 || tog;
      end else if (mode == 1) begin
         q = {8'h00, addr[1:0] == 2'b00 ? MAKER_ID : addr[1:0] == 2'b01 ? PART_ID : 8'h00};
      end else begin
         q = rm(addr);
      end
      dq_in = q;
   end
   // released bus shows the inverse so a stale value never passes
   always @(posedge rd_n) dq_in = ~q;
endmodule // flash_dev_model

/* tb/parallel_flash_command_interface_tb_top.sv */
`timescale 1ns/10ps
module parallel_flash_command_interface_tb_top
   import flash_host_pkg::*;
;
   localparam logic [7:0] MAKER = 8'h3C; // arbitrary
   localparam logic [7:0] PART = 8'hC3; // arbitrary
   logic clock, rst_n, reg_write, reg_read, dq_oe, ce_n, oe_n, we_n, byte_n;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, dq_out, dq_in, g;
   logic [17:0] fa;
   logic [15:0] sh [int];
   int err_total = 0;
   int checked = 0;
   int seed = 32'h93f7;
   flash_host #(.RESET_WAIT(20)) i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_byte_n(byte_n));
   flash_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_dev (.addr(fa), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .byte_n(byte_n));
   task automatic results();
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clock);
   endtask
   task automatic op(input logic [2:0] c, input logic [17:0] a, input logic w);
      logic [15:0] s;
      wr(REG_ADDRESS, a[15:0]);
      wr(REG_CONTROL, {6'h00, a[17:16], 3'h0, w, 1'b0, c});
      s = 16'h0001;
      for (int n = 0; n < 400 && s[0] !== 1'b0; n++) rd(REG_STATUS, s);
      chk(s & 16'h0001, 16'h0000);
   endtask
   task automatic fr(input logic [17:0] a, input logic w, output logic [15:0] d);
      op(OP_READ, a, w);
      rd(REG_RDATA, d);
   endtask
   // completion is seen only through reads, so poll with a bound
   task automatic poll(input logic [17:0] a, input logic w, input logic [15:0] e,
                       input logic [15:0] m);
      logic [15:0] d;
      fr(a, w, d);
      for (int n = 0; n < 1000 && (d & m) !== (e & m); n++) fr(a, w, d);
      chk(d & m, e & m);
   endtask
   function automatic logic [15:0] old(input logic [17:0] a);
      return sh.exists(a) ? sh[a] : 16'hFFFF;
   endfunction
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (90000) @(posedge clock);
      err_total++;
      results();
   end
   initial begin
      logic [17:0] a;
      logic [15:0] d;
      time t;
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(REG_STATUS, g);
      chk(g, RESET_VALUE_ZERO);
      chk({12'h000, ce_n, oe_n, we_n, dq_oe}, 16'h000E);
      wr(4'hF, 16'hFFFF);
      rd(REG_STATUS, g);
      chk(g & 16'h0001, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         a = 18'h00040 + 18'(($random(seed) & 3) * 2);
         d = $random(seed);
         sh[a] = old(a) & d;
         wr(REG_WDATA, d);
         op(OP_PROGRAM, a, 1'b1);
         fr(a, 1'b1, g);
         chk(g & 16'h0080, ~d & 16'h0080);
         poll(a, 1'b1, sh[a], 16'hFFFF);
      end
      d = $random(seed);
      wr(REG_WDATA, d);
      op(OP_PROGRAM, 18'h00100, 1'b0);
      poll(18'h00100, 1'b0, d, 16'h00FF);
      op(OP_AUTO_SELECT, 18'h00000, 1'b1);
      fr(18'h00000, 1'b1, g);
      chk(g & 16'h00FF, {8'h00, MAKER});
      fr(18'h00001, 1'b1, g);
      chk(g & 16'h00FF, {8'h00, PART});
      fr(18'h05002, 1'b1, g);
      chk(g & 16'h00FF, 16'h0000);
      op(OP_RESET, 18'h00000, 1'b1);
      fr(a, 1'b1, g);
      chk(g, sh[a]);
      d = $random(seed);
      wr(REG_WDATA, d);
      op(OP_PROGRAM, 18'h01010, 1'b1);
      poll(18'h01010, 1'b1, d, 16'hFFFF);
      op(OP_ERASE, 18'h00040, 1'b1);
      fr(18'h00040, 1'b1, g);
      chk(g & 16'h0088, 16'h0000);
      fr(18'h00040, 1'b1, g);
      rd(REG_STATUS, g);
      chk(g & 16'h0004, 16'h0004);
      op(OP_ERASE_MORE, 18'h02000, 1'b1);
      poll(18'h00040, 1'b1, 16'hFFFF, 16'hFFFF);
      fr(18'h01010, 1'b1, g);
      chk(g, d);
      // a lone confirm outside the window must leave data alone
      op(OP_ERASE_MORE, 18'h01010, 1'b1);
      fr(18'h01010, 1'b1, g);
      chk(g, d);
      // reset after an erase must hold the host busy for the settle wait
      t = $time;
      op(OP_RESET, 18'h00000, 1'b1);
      chk(16'(($time - t) >= 300), 16'h0001);
      rd(REG_STATUS, g);
      chk(g & 16'h000B, 16'h0000);
      results();
   end
endmodule // parallel_flash_command_interface_tb_top
